// ### design/filter_serial_control_port.sv
`timescale 1ns/10ps
`include "filter_serial_map.svh"

// Functional notes
// - Select low: configuration from serial port
// - Sample data on rising clock, MSB first
// - Next shift bit to data out on fall
// - Select rising copies word into control register
// - Shift clock gated while select high
// - Serial data out always driven, serial mode
// - Data out keeps last bit after select
// - Daisy chain: out feeds next input
// - Word order gain, lowpass, highpass, down, out
// - Gain code from bits six and seven
// - Gain codes map to 0/12/24/30 dB
// - Bit one set enters shutdown
// - Bit zero drives general output pin
// - Lowpass codes give 150/300/900 kHz
// - Highpass codes 15/45/90 kHz or bypass
// - Cutoffs scale with master clock
// - Lowest lowpass code reduces power
// - External clock when clock select low
// - Select high: configuration from pins
// - One setting shared by both channels

module filter_serial_control_port (
    input  wire logic clk,               // System clock, 50 MHz
    input  wire logic reset,             // Synchronous, active high
    input  wire logic serialClk,         // Serial clock pin, link domain
    input  wire logic chipSelectN,       // Chip select / lowpass_code_hi
    input  wire logic serialDataIn,      // Data in / highpass_code_hi
    input  wire logic serial_mode_select_n, // Low = serial interface
    input  wire logic amp_code_hi,       // Gain MSB pin, pin mode
    input  wire logic lowpass_code_lo,   // Lowpass LSB pin, pin mode
    input  wire logic highpassLoIn,      // Highpass LSB pin input side
    output logic      serialDataOut,     // Highpass LSB pin output side
    output logic      serialDataOutEn,   // Output enable, serial mode
    input  wire logic ampLoIn,           // Gain LSB pin input side
    output logic      generalOut,        // Gain LSB pin output side
    output logic      generalOutEn,      // Output enable, serial mode
    input  wire logic clock_source_select, // Low = external clock
    input  wire logic master_clock_pin,  // External master clock level
    output logic      externalClockSel,  // Master clock from pin
    output logic      masterClock,       // External clock level when selected, else low
    output filter_serial_pkg::channel_setting_type channelA, // Channel A
    output filter_serial_pkg::channel_setting_type channelB, // Channel B
    output filter_serial_pkg::control_word_type    controlWord, // Latch
    output logic      wordLoaded,        // A word has been latched
    output logic      loadPulse          // One cycle per latched word
);

    ////////////////////////////////////////////////////////////////////
    // Link domain: shift register and serial output

    logic [`CTRL_WIDTH-1:0] shift_q;
    logic                   sdo_q;

    // MSB first shifting
    // Select is the frame qualifier, so it is read directly here
    always_ff @(posedge serialClk) begin
        if (!chipSelectN) begin
            shift_q <= {shift_q[`CTRL_WIDTH-2:0], serialDataIn};
        end
    end

    // MSB leaves first for the next device
    always_ff @(negedge serialClk) begin
        if (!chipSelectN) begin
            sdo_q <= shift_q[`CTRL_WIDTH-1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers into the system domain

    logic       csSync;
    logic       modeSelNSync;
    logic       clkSelSync;
    logic       extClkSync;
    logic [5:0] pinCodeSync;

    sync_two_flop #(
        .WIDTH(1)
    ) csSyncInst (
        .clk    (clk),
        .asyncIn(chipSelectN),
        .syncOut(csSync)
    );

    sync_two_flop #(
        .WIDTH(1)
    ) modeSyncInst (
        .clk    (clk),
        .asyncIn(serial_mode_select_n),
        .syncOut(modeSelNSync)
    );

    sync_two_flop #(
        .WIDTH(1)
    ) clkSelSyncInst (
        .clk    (clk),
        .asyncIn(clock_source_select),
        .syncOut(clkSelSync)
    );

    sync_two_flop #(
        .WIDTH(1)
    ) extClkSyncInst (
        .clk    (clk),
        .asyncIn(master_clock_pin),
        .syncOut(extClkSync)
    );

    // Pin-mode code pins; the shared pins double as serial lines
    sync_two_flop #(
        .WIDTH(6)
    ) pinSyncInst (
        .clk    (clk),
        .asyncIn({amp_code_hi, ampLoIn, chipSelectN,
                  lowpass_code_lo, serialDataIn, highpassLoIn}),
        .syncOut(pinCodeSync)
    );

    ////////////////////////////////////////////////////////////////////
    // Mode selection

    filter_serial_pkg::config_mode_type mode_q;
    filter_serial_pkg::config_mode_type mode_d;

    assign mode_d = modeSelNSync ? filter_serial_pkg::MODE_PINS
                                 : filter_serial_pkg::MODE_SERIAL;

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= filter_serial_pkg::MODE_PINS;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire serialMode = (mode_q == filter_serial_pkg::MODE_SERIAL);

    ////////////////////////////////////////////////////////////////////
    // Word capture on rising chip select

    logic                   csPrev_q;
    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic [`CTRL_WIDTH-1:0] ctrl_d;
    logic                   loaded_q;
    logic                   loadPulse_q;

    wire csRise = csSync & ~csPrev_q;

    // The shift register is frozen while select is high, and the
    // synchronised edge arrives two cycles late, so the word is
    // stable when sampled. A frame shorter than about three system
    // clocks of select-high time is not supported.
    // parallel load on rise
    assign ctrl_d = (csRise && serialMode) ? shift_q : ctrl_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            csPrev_q <= 1'b1;
        end else begin
            csPrev_q <= csSync;
        end
    end

    // word reads as CTRL_RESET (zero) before the first load
    // Reset value is a safe default; wordLoaded tells the difference
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= `CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loaded_q    <= 1'b0;
            loadPulse_q <= 1'b0;
        end else begin
            loaded_q    <= loaded_q | (csRise & serialMode);
            loadPulse_q <= csRise & serialMode;
        end
    end

    assign wordLoaded = loaded_q;
    assign loadPulse  = loadPulse_q;

    ////////////////////////////////////////////////////////////////////
    // Field extraction

    filter_serial_pkg::control_word_type serialWord;
    filter_serial_pkg::control_word_type pinWord;
    filter_serial_pkg::control_word_type activeWord;

    assign serialWord.ampCode      = {ctrl_q[`POS_AMP_HI],
                                      ctrl_q[`POS_AMP_LO]};
    assign serialWord.lowpassCode  = {ctrl_q[`POS_LOWPASS_HI],
                                      ctrl_q[`POS_LOWPASS_LO]};
    assign serialWord.highpassCode = {ctrl_q[`POS_HIGHPASS_HI],
                                      ctrl_q[`POS_HIGHPASS_LO]};
    assign serialWord.powerDown    = ctrl_q[`POS_POWER_DOWN];
    assign serialWord.generalOut   = ctrl_q[`POS_GENERAL_OUT];

    // Pin mode has no shutdown and no general output
    assign pinWord.ampCode      = pinCodeSync[5:4];
    assign pinWord.lowpassCode  = pinCodeSync[3:2];
    assign pinWord.highpassCode = pinCodeSync[1:0];
    assign pinWord.powerDown    = 1'b0;
    assign pinWord.generalOut   = 1'b0;

    assign activeWord = serialMode ? serialWord : pinWord;

    ////////////////////////////////////////////////////////////////////
    // Decode into filter settings

    logic [5:0]  gainDb;
    logic [12:0] lowpassDiv;
    logic [12:0] highpassDiv;
    logic [9:0]  lowpassKhz;
    logic [9:0]  highpassKhz;

    always_comb begin
        unique case (activeWord.ampCode)
            2'h0: gainDb = `GAIN_DB_CODE0;
            2'h1: gainDb = `GAIN_DB_CODE1;
            2'h2: gainDb = `GAIN_DB_CODE2;
            2'h3: gainDb = `GAIN_DB_CODE3;
        endcase
    end

    always_comb begin
        unique case (activeWord.lowpassCode)
            2'h0: begin
                lowpassDiv = `LOWPASS_DIV_CODE0;
                lowpassKhz = `LOWPASS_KHZ_CODE0;
            end
            2'h1: begin
                lowpassDiv = `LOWPASS_DIV_CODE1;
                lowpassKhz = `LOWPASS_KHZ_CODE1;
            end
            2'h2, 2'h3: begin
                lowpassDiv = `LOWPASS_DIV_CODE2;
                lowpassKhz = `LOWPASS_KHZ_CODE2;
            end
        endcase
    end

    always_comb begin
        unique case (activeWord.highpassCode)
            2'h0: begin
                highpassDiv = `HIGHPASS_DIV_CODE0;
                highpassKhz = `HIGHPASS_KHZ_CODE0;
            end
            2'h1: begin
                highpassDiv = `HIGHPASS_DIV_CODE1;
                highpassKhz = `HIGHPASS_KHZ_CODE1;
            end
            2'h2: begin
                highpassDiv = `HIGHPASS_DIV_CODE2;
                highpassKhz = `HIGHPASS_KHZ_CODE2;
            end
            2'h3: begin
                highpassDiv = 13'h0000;
                highpassKhz = `HIGHPASS_KHZ_NONE;
            end
        endcase
    end

    filter_serial_pkg::channel_setting_type setting_d;
    filter_serial_pkg::channel_setting_type setting_q;

    assign setting_d.gainDb          = gainDb;
    assign setting_d.lowpassDivisor  = lowpassDiv;
    assign setting_d.highpassDivisor = highpassDiv;
    assign setting_d.lowpassKhz      = lowpassKhz;
    assign setting_d.highpassKhz     = highpassKhz;
    assign setting_d.highpassBypass  =
        (activeWord.highpassCode == `HIGHPASS_BYPASS);
    assign setting_d.lowPower        =
        (activeWord.lowpassCode == `LOWPASS_LOW_POWER);
    assign setting_d.powerDown       = activeWord.powerDown;

    // Registered so the filter never sees a decode glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            setting_q <= '0;
        end else begin
            setting_q <= setting_d;
        end
    end

    assign channelA    = setting_q;
    assign channelB    = setting_q;
    assign controlWord = serialWord;

    ////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic generalOut_q;
    logic serialOe_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            generalOut_q <= 1'b0;
            serialOe_q   <= 1'b0;
        end else begin
            generalOut_q <= serialWord.generalOut;
            serialOe_q   <= serialMode;
        end
    end

    assign serialDataOut   = sdo_q;
    assign serialDataOutEn = serialOe_q;

    assign generalOut   = generalOut_q;
    assign generalOutEn = serialOe_q;

    ////////////////////////////////////////////////////////////////////
    // Master clock source

    logic extSel_q;
    logic masterClock_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            extSel_q      <= 1'b0;
            masterClock_q <= 1'b0;
        end else begin
            extSel_q      <= ~clkSelSync;
            masterClock_q <= ~clkSelSync & extClkSync;
        end
    end

    // Level view only; the real filter clock never passes through here
    assign externalClockSel = extSel_q;
    assign masterClock      = masterClock_q;

endmodule : filter_serial_control_port

// ### design/filter_serial_map.svh
`ifndef FILTER_SERIAL_MAP_SVH
`define FILTER_SERIAL_MAP_SVH

// Control word width and field positions
`define CTRL_WIDTH          8
`define CTRL_RESET          8'h00
`define POS_AMP_LO          7
`define POS_AMP_HI          6
`define POS_LOWPASS_LO      5
`define POS_LOWPASS_HI      4
`define POS_HIGHPASS_LO     3
`define POS_HIGHPASS_HI     2
`define POS_POWER_DOWN      1
`define POS_GENERAL_OUT     0

// Passband gain per two-bit code, in dB
`define GAIN_DB_CODE0       6'h00
`define GAIN_DB_CODE1       6'h0C
`define GAIN_DB_CODE2       6'h18
`define GAIN_DB_CODE3       6'h1E

// Cutoff = master clock / divisor (150, 300, 900 kHz at 90 MHz)
`define LOWPASS_DIV_CODE0   13'h0258
`define LOWPASS_DIV_CODE1   13'h012C
`define LOWPASS_DIV_CODE2   13'h0064
// Highpass 15, 45, 90 kHz at 90 MHz
`define HIGHPASS_DIV_CODE0  13'h1770
`define HIGHPASS_DIV_CODE1  13'h07D0
`define HIGHPASS_DIV_CODE2  13'h03E8
`define HIGHPASS_BYPASS     2'h3

// Nominal cutoffs in kHz at the nominal master clock
`define LOWPASS_KHZ_CODE0   10'h096
`define LOWPASS_KHZ_CODE1   10'h12C
`define LOWPASS_KHZ_CODE2   10'h384
`define HIGHPASS_KHZ_CODE0  10'h00F
`define HIGHPASS_KHZ_CODE1  10'h02D
`define HIGHPASS_KHZ_CODE2  10'h05A
`define HIGHPASS_KHZ_NONE   10'h000

// Lowest lowpass code runs the filter at reduced power
`define LOWPASS_LOW_POWER   2'h0

// Synchroniser depth for pin inputs
`define SYNC_STAGES         2

`endif

// ### design/filter_serial_pkg.sv
package filter_serial_pkg;

    typedef enum logic {
        MODE_SERIAL,
        MODE_PINS
    } config_mode_type;

    typedef struct packed {
        logic [1:0] ampCode;
        logic [1:0] lowpassCode;
        logic [1:0] highpassCode;
        logic       powerDown;
        logic       generalOut;
    } control_word_type;

    typedef struct packed {
        logic [5:0]  gainDb;
        logic [12:0] lowpassDivisor;
        logic [12:0] highpassDivisor;
        logic [9:0]  lowpassKhz;
        logic [9:0]  highpassKhz;
        logic        highpassBypass;
        logic        lowPower;
        logic        powerDown;
    } channel_setting_type;

endpackage : filter_serial_pkg

// ### design/sync_two_flop.sv
`timescale 1ns/10ps
`include "filter_serial_map.svh"

module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,     // Destination clock
    input  wire logic [WIDTH-1:0] asyncIn, // Level from another domain
    output logic      [WIDTH-1:0] syncOut  // Level after two flops
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // First stage feeds only the second; no reset so metastability
    // settles rather than being masked
    always_ff @(posedge clk) begin
        stage1_q <= asyncIn;
        stage2_q <= stage1_q;
    end

    assign syncOut = stage2_q;

endmodule : sync_two_flop

// ### testbench/filter_serial_control_port_chk.sv
`timescale 1ns/10ps
module filter_serial_control_port_chk (
    input wire logic clk,             // System clock
    input wire logic reset,           // Sync reset
    input wire logic chipSelectN,     // Select pin
    input wire logic serialDataOutEn, // High in serial mode
    input wire logic generalOut,      // D0 pin
    input wire logic loadPulse,       // Word latched
    input wire filter_serial_pkg::control_word_type    controlWord, // Latch
    input wire filter_serial_pkg::channel_setting_type channelA,    // Ch A
    input wire filter_serial_pkg::channel_setting_type channelB     // Ch B
);
    localparam logic [5:0] GDB [4] = '{6'h00, 6'h0C, 6'h18, 6'h1E};
    localparam logic [9:0] LPK [4] = '{10'h096, 10'h12C, 10'h384, 10'h384};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    a_load_follow: assert property (
        $rose(chipSelectN) && serialDataOutEn |-> ##[1:5] loadPulse)
        else $error("no load after select rise");
    a_pulse_single: assert property (loadPulse |=> !loadPulse)
        else $error("load pulse too long");
    a_word_holds: assert property (
        !loadPulse |-> $stable(controlWord))
        else $error("word changed without load");
    a_gain_map: assert property (
        loadPulse |=> channelA.gainDb == GDB[controlWord.ampCode])
        else $error("gain mismatch");
    a_lowpass_map: assert property (loadPulse |=>
        channelA.lowpassKhz == LPK[controlWord.lowpassCode] &&
        channelA.lowPower == (controlWord.lowpassCode == 2'h0))
        else $error("lowpass mismatch");
    a_highpass_byp: assert property (loadPulse |=>
        channelA.highpassBypass == (controlWord.highpassCode == 2'h3))
        else $error("bypass mismatch");
    a_shutdown_out: assert property (loadPulse |=>
        channelA.powerDown == controlWord.powerDown &&
        generalOut == controlWord.generalOut)
        else $error("shutdown or output mismatch");
    a_chan_equal: assert property (channelA == channelB)
        else $error("channels differ");

    c_shutdown: cover property (loadPulse && controlWord.powerDown);
    c_bypass: cover property (loadPulse && controlWord.highpassCode == 2'h3);
    c_pin_mode: cover property ($fell(serialDataOutEn));
endmodule : filter_serial_control_port_chk

bind filter_serial_control_port filter_serial_control_port_chk i_chk (
    .clk(clk), .reset(reset), .chipSelectN(chipSelectN),
    .serialDataOutEn(serialDataOutEn), .generalOut(generalOut),
    .loadPulse(loadPulse), .controlWord(controlWord),
    .channelA(channelA), .channelB(channelB)
);

// ### testbench/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
    output logic      serialClk,    // Link clock, stray pulses possible between frames
    output logic      chipSelectN,  // Frame select
    output logic      serialDataIn, // Data to device
    input  wire logic serialDataOut // Device output pin level
);
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialDataIn = 1'b0;
    end

    task automatic frame(input logic [15:0] d, input int n, input int stray,
                         input int slow, output logic [15:0] got);
        int i;
        got = 16'h0000;
        repeat (stray) begin
            #7.5 serialClk = 1'b1;
            #7.5 serialClk = 1'b0;
        end
        #4 chipSelectN = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            serialDataIn = d[i];
            #(3.75 + slow) got[i] = serialDataOut;
            #3.75 serialClk = 1'b1;
            #7.5 serialClk = 1'b0;
        end
        // one select rise for whole chain
        #4 chipSelectN = 1'b1;
        serialDataIn = ~serialDataIn;
    endtask : frame
endmodule : spi_host_model

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [5:0]  GDB [4] = '{6'h00, 6'h0C, 6'h18, 6'h1E};
    localparam logic [12:0] LPD [4] =
        '{13'h0258, 13'h012C, 13'h0064, 13'h0064};
    localparam logic [12:0] HPD [4] =
        '{13'h1770, 13'h07D0, 13'h03E8, 13'h0000};
    localparam logic [9:0]  LPK [4] = '{10'h096, 10'h12C, 10'h384, 10'h384};
    localparam logic [9:0]  HPK [4] = '{10'h00F, 10'h02D, 10'h05A, 10'h000};
    logic   clk, reset, serN, ampHi, lpHi, lpLo, hpHi, hpLo, ampLo;
    logic   clkSel, mclkPin, known;
    logic   [7:0] shr;
    wire    sck, hostCsN, hostSdi, sdo, sdoEn, gpo, gpoEn, extSel, mclk;
    wire    loaded, pulse;
    wire    sdoPin = sdoEn ? sdo : hpLo;
    int     err_total, checked;
    integer seed;
    filter_serial_pkg::channel_setting_type chA, chB;
    filter_serial_pkg::control_word_type    cw;

    filter_serial_control_port i_filter_serial_control_port (
        .clk(clk), .reset(reset), .serialClk(sck),
        .chipSelectN(serN ? lpHi : hostCsN),
        .serialDataIn(serN ? hpHi : hostSdi),
        .serial_mode_select_n(serN), .amp_code_hi(ampHi),
        .lowpass_code_lo(lpLo), .highpassLoIn(sdoPin),
        .serialDataOut(sdo), .serialDataOutEn(sdoEn),
        .ampLoIn(gpoEn ? gpo : ampLo), .generalOut(gpo), .generalOutEn(gpoEn),
        .clock_source_select(clkSel), .master_clock_pin(mclkPin),
        .externalClockSel(extSel), .masterClock(mclk), .channelA(chA),
        .channelB(chB), .controlWord(cw), .wordLoaded(loaded),
        .loadPulse(pulse)
    );
    spi_host_model i_spi_host_model (
        .serialClk(sck), .chipSelectN(hostCsN), .serialDataIn(hostSdi),
        .serialDataOut(sdoPin)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ctl(input logic [7:0] w);
        return {w[6], w[7], w[4], w[5], w[2], w[3], w[1:0]};
    endfunction : ctl

    function automatic filter_serial_pkg::channel_setting_type chan(
            input logic [7:0] c);
        return {GDB[c[7:6]], LPD[c[5:4]], HPD[c[3:2]], LPK[c[5:4]],
                HPK[c[3:2]], c[3:2] == 2'h3, c[5:4] == 2'h0, c[1]};
    endfunction : chan

    task automatic cmpV(input logic [15:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask : cmpV

    task automatic cmpCh(input filter_serial_pkg::channel_setting_type got,
                         exp, input string m);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask : cmpCh

    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Shadow shift register predicts both the word and the chained bits
    task automatic send(input logic [15:0] d, input int n, stray, slow);
        logic [15:0] g, eg;
        int          i;
        eg = 16'h0000;
        for (i = n - 1; i >= 0; i--) begin
            eg[i] = shr[7];
            shr = {shr[6:0], d[i]};
        end
        i_spi_host_model.frame(d, n, stray, slow, g);
        if (known) cmpV(g, eg, "sdo");
        known = 1'b1;
        i = 0;
        while (pulse !== 1'b1 && i < 12) begin
            @(negedge clk);
            i++;
        end
        cmpV({15'h0000, pulse}, 16'h0001, "load");
        cmpV({8'h00, cw}, {8'h00, ctl(shr)}, "word");
        @(negedge clk);
        cmpCh(chA, chan(ctl(shr)), "chA");
        cmpCh(chB, chan(ctl(shr)), "chB");
        cmpV({15'h0000, gpo}, {15'h0000, shr[0]}, "gpo");
        // Select must stay high at least four clocks between frames
        @(negedge clk);
    endtask : send

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        int k;
        int n;
        seed = 32'h084e;
        reset = 1'b1;
        {serN, ampHi, lpHi, lpLo, hpHi, hpLo, ampLo, clkSel, mclkPin} = 9'h000;
        known = 1'b0;
        shr = 8'h00;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        cmpV({15'h0000, loaded}, 16'h0000, "loaded");
        repeat (4) @(negedge clk);
        send(16'h00A5, 8, 0, 0);
        cmpV({15'h0000, loaded}, 16'h0001, "loaded");
        // Every code of every field, stray clocks in front
        for (k = 0; k < 4; k++) begin
            send({8'h00, {4{k[1:0]}}}, 8, k, 0);
        end
        for (k = 0; k < 16; k++) begin
            {clkSel, mclkPin} = 2'($random(seed));
            n = (k % 4 == 1) ? 16 : (k % 4 == 2) ? 3 : 8;
            send(16'($random(seed)), n, k % 2, {$random(seed)} % 12);
            cmpV({15'h0000, extSel}, {15'h0000, ~clkSel}, "xsel");
            if (!clkSel) begin
                cmpV({15'h0000, mclk}, {15'h0000, mclkPin}, "mck");
            end
        end
        lpHi = 1'b1;
        serN = 1'b1;
        repeat (6) @(negedge clk);
        {ampHi, ampLo, lpHi, lpLo, hpHi, hpLo} = 6'($random(seed));
        repeat (6) @(negedge clk);
        cmpCh(chA, chan({ampHi, ampLo, lpHi, lpLo, hpHi, hpLo, 2'h0}),
              "pin");
        cmpV({14'h0000, sdoEn, gpoEn}, 16'h0000, "oe");
        lpHi = 1'b1;
        repeat (6) @(negedge clk);
        cmpV({8'h00, cw}, {8'h00, ctl(shr)}, "held");
        serN = 1'b0;
        repeat (6) @(negedge clk);
        cmpCh(chA, chan(ctl(shr)), "ser");
        cmpV({14'h0000, sdoEn, gpoEn}, 16'h0003, "oe");
        send(16'h003C, 8, 0, 3);
        tally_and_finish();
    end
endmodule : testbench
